// file: hdl/srap_top.sv
// Purpose: Shared-pin I2C and SPI slave onto an internal register array
// Assumes: Serial port clock is SPI clock and I2C clock on one pin
// Notes: SPI reads see the array as quasi-static data
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Chip select high: I2C on; low: SPI
// - SPI modes 0 and 3, 3 or 4 wire
// - I2C-off bit at 13h kills I2C slave
// - I2C address 110101 plus select pin
// - First byte: address and direction bit
// - Receiver pulls data low during acknowledge
// - Subaddress then acknowledged write data bytes
// - Read after repeated start; host acks continue
// - Bytes of eight bits, MSB first, unlimited
// - Unmatched address left high; stop ends transfer
// - Standard and fast mode up to 400 kHz
// - Auto-increment bit steers burst register index
// - Chip select frames SPI; sample rising edges
// - Sixteen pulses, plus eight per extra byte
// - Bits start on falling clock edges
// - Bit 0 direction, bits 1-7 index
// - Read data driven from bit 8, MSB first
// - Write bits 8-15 stored to indexed register
// - Three-wire bit sends reads on data pin
module srap_top #(
    parameter int FILT_CYCLES = srap_pkg::FILT_CYCLES
) (
    // System
    input wire logic clock,
    input wire logic sys_rst,
    // Serial pins
    input wire logic cs_n,
    input wire logic serial_port_clock,
    input wire logic serial_data_i,
    output logic serial_data_o,
    output logic serial_data_oe_n,
    input wire logic address_select_pin_i,
    output logic address_select_pin_o,
    output logic address_select_pin_oe_n,
    // Configuration seen by the sensor core
    output logic auto_increment,
    output logic three_wire_mode,
    output logic i2c_disabled,
    // Register write events
    output logic reg_write_pulse,
    output srap_pkg::srap_wr_s reg_write
);

    localparam int FW = $clog2(FILT_CYCLES + 1);

    // Register array
    logic [7:0] regs [srap_pkg::REG_DEPTH];

    // Pin synchronisers
    logic [3:0] pin_s;
    logic scl_s;
    logic sda_s;
    logic sel_s;
    logic cs_s;

    // Spike filters
    logic [1:0] line_raw;
    logic [1:0] line_f;
    logic [FW-1:0] filt_cnt [2];
    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;

    // Bus events
    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;
    logic i2c_on;

    // I2C slave
    srap_pkg::srap_i2c_e i2c_state;
    srap_pkg::srap_i2c_e after_ack;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic i2c_drive;
    logic host_acked;
    logic [6:0] i2c_index;
    logic [6:0] own_addr;
    logic byte_done;
    logic addr_hit;
    logic [7:0] i2c_rd_byte;
    logic i2c_wr_fire;

    // SPI link side
    logic [1:0] link_cfg;
    logic [6:0] spi_index;
    logic [7:0] spi_rd_byte;
    logic spi_bit;
    logic spi_sda_oe_n;
    logic spi_pin_oe_n;
    logic spi_toggle;
    srap_pkg::srap_wr_s spi_wr_req;
    logic spi_toggle_s;
    logic spi_toggle_q;
    logic spi_wr_fire;

    // Register writes
    logic wr_fire;
    srap_pkg::srap_wr_s wr_sel;
    srap_pkg::srap_wr_s i2c_wr_req;

    srap_sync #(
        .W(4),
        .RST_VAL(srap_pkg::PIN_IDLE)
    ) u_pin_sync (
        .clock(clock),
        .rst(sys_rst),
        .d({serial_port_clock, serial_data_i, address_select_pin_i, cs_n}),
        .q(pin_s)
    );

    assign scl_s = pin_s[3];
    assign sda_s = pin_s[2];
    assign sel_s = pin_s[1];
    assign cs_s = pin_s[0];
    assign line_raw = {scl_s, sda_s};

    // Glitch filter for both I2C lines
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            line_f <= 2'h3;
            for (int i = 0; i < 2; i++) begin
                filt_cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (line_raw[i] == line_f[i]) begin
                    filt_cnt[i] <= '0;
                end else if (filt_cnt[i] == FW'(FILT_CYCLES - 1)) begin
                    filt_cnt[i] <= '0;
                    line_f[i] <= line_raw[i];
                end else begin
                    filt_cnt[i] <= filt_cnt[i] + 1'b1;
                end
            end
        end
    end

    assign scl_f = line_f[1];
    assign sda_f = line_f[0];

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    // Start, stop and clock edges
    assign start_cond = scl_f & scl_q & sda_q & ~sda_f;
    assign stop_cond = scl_f & scl_q & ~sda_q & sda_f;
    assign scl_rise = scl_f & ~scl_q;
    assign scl_fall = ~scl_f & scl_q;
    assign i2c_on = cs_s & ~i2c_disabled;

    // Address and byte decode
    assign own_addr = {srap_pkg::I2C_ADDR_HIGH, sel_s};
    assign byte_done = bit_cnt == srap_pkg::I2C_BYTE_BITS;
    assign addr_hit = shreg[7:1] == own_addr;
    assign i2c_rd_byte = regs[i2c_index];
    assign i2c_wr_fire = i2c_on & scl_fall & byte_done &
                         (i2c_state == srap_pkg::I2C_WRITE);

    // I2C slave sequencer
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            i2c_state <= srap_pkg::I2C_IDLE;
            after_ack <= srap_pkg::I2C_IDLE;
            bit_cnt <= '0;
            shreg <= '0;
            tx <= '0;
            i2c_drive <= 1'b0;
            host_acked <= 1'b0;
            i2c_index <= '0;
        end else if (!i2c_on || stop_cond) begin
            i2c_state <= srap_pkg::I2C_IDLE;
            i2c_drive <= 1'b0;
        end else if (start_cond) begin
            i2c_state <= srap_pkg::I2C_ADDR;
            bit_cnt <= '0;
            i2c_drive <= 1'b0;
        end else if (scl_rise) begin
            if (!byte_done) begin
                shreg <= {shreg[6:0], sda_f};
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (i2c_state == srap_pkg::I2C_READ) begin
                tx <= {tx[6:0], 1'b0};
            end
            if (i2c_state == srap_pkg::I2C_HOST_ACK) begin
                host_acked <= ~sda_f;
            end
        end else if (scl_fall) begin
            unique case (i2c_state)
                srap_pkg::I2C_IDLE: begin
                    i2c_drive <= 1'b0;
                end
                srap_pkg::I2C_ADDR: begin
                    if (byte_done && addr_hit) begin
                        i2c_drive <= 1'b1;
                        i2c_state <= srap_pkg::I2C_ACK;
                        after_ack <= shreg[0] ? srap_pkg::I2C_READ
                                              : srap_pkg::I2C_SUB;
                    end else if (byte_done) begin
                        i2c_state <= srap_pkg::I2C_IDLE;
                    end
                end
                srap_pkg::I2C_SUB: begin
                    if (byte_done) begin
                        i2c_index <= shreg[6:0];
                        i2c_drive <= 1'b1;
                        i2c_state <= srap_pkg::I2C_ACK;
                        after_ack <= srap_pkg::I2C_WRITE;
                    end
                end
                srap_pkg::I2C_WRITE: begin
                    if (byte_done) begin
                        i2c_index <= srap_pkg::srap_next_index(
                            i2c_index, auto_increment);
                        i2c_drive <= 1'b1;
                        i2c_state <= srap_pkg::I2C_ACK;
                        after_ack <= srap_pkg::I2C_WRITE;
                    end
                end
                srap_pkg::I2C_ACK: begin
                    bit_cnt <= '0;
                    tx <= i2c_rd_byte;
                    i2c_drive <= (after_ack == srap_pkg::I2C_READ) &
                                 ~i2c_rd_byte[7];
                    i2c_state <= after_ack;
                end
                srap_pkg::I2C_READ: begin
                    if (byte_done) begin
                        i2c_drive <= 1'b0;
                        i2c_index <= srap_pkg::srap_next_index(
                            i2c_index, auto_increment);
                        i2c_state <= srap_pkg::I2C_HOST_ACK;
                    end else begin
                        i2c_drive <= ~tx[7];
                    end
                end
                srap_pkg::I2C_HOST_ACK: begin
                    if (host_acked) begin
                        bit_cnt <= '0;
                        tx <= i2c_rd_byte;
                        i2c_drive <= ~i2c_rd_byte[7];
                        i2c_state <= srap_pkg::I2C_READ;
                    end else begin
                        i2c_state <= srap_pkg::I2C_IDLE;
                    end
                end
            endcase
        end
    end

    // Link-side configuration and SPI engine
    srap_sync #(
        .W(2)
    ) u_link_sync (
        .clock(serial_port_clock),
        .rst(sys_rst),
        .d({auto_increment, three_wire_mode}),
        .q(link_cfg)
    );

    assign spi_rd_byte = regs[spi_index];

    srap_spi_link u_spi (
        .serial_port_clock(serial_port_clock),
        .sys_rst(sys_rst),
        .cs_n(cs_n),
        .data_in(serial_data_i),
        .out_bit(spi_bit),
        .sda_oe_n(spi_sda_oe_n),
        .pin_oe_n(spi_pin_oe_n),
        .auto_inc_l(link_cfg[1]),
        .three_wire_l(link_cfg[0]),
        .rd_byte(spi_rd_byte),
        .index(spi_index),
        .wr_toggle(spi_toggle),
        .wr_req(spi_wr_req)
    );

    // SPI write event crossing
    srap_sync #(
        .W(1)
    ) u_wr_sync (
        .clock(clock),
        .rst(sys_rst),
        .d(spi_toggle),
        .q(spi_toggle_s)
    );

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            spi_toggle_q <= 1'b0;
        end else begin
            spi_toggle_q <= spi_toggle_s;
        end
    end

    assign spi_wr_fire = spi_toggle_s ^ spi_toggle_q;
    assign wr_fire = spi_wr_fire | i2c_wr_fire;
    assign i2c_wr_req = '{index: i2c_index, data: shreg};
    assign wr_sel = spi_wr_fire ? spi_wr_req : i2c_wr_req;

    // Register array and write events
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < srap_pkg::REG_DEPTH; i++) begin
                regs[i] <= srap_pkg::REG_RESET;
            end
        end else if (wr_fire) begin
            regs[wr_sel.index] <= wr_sel.data;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_write_pulse <= 1'b0;
            reg_write <= '0;
        end else begin
            reg_write_pulse <= wr_fire;
            reg_write <= wr_sel;
        end
    end

    // Configuration bits
    assign auto_increment =
        regs[srap_pkg::IFACE_CTRL_IDX][srap_pkg::AUTO_INC_BIT];
    assign three_wire_mode =
        regs[srap_pkg::IFACE_CTRL_IDX][srap_pkg::THREE_WIRE_BIT];
    assign i2c_disabled =
        regs[srap_pkg::SEC_CTRL_IDX][srap_pkg::I2C_OFF_BIT];

    // Pin drivers
    assign serial_data_o = spi_sda_oe_n ? 1'b0 : spi_bit;
    assign serial_data_oe_n = spi_sda_oe_n & ~i2c_drive;
    assign address_select_pin_o = spi_bit;
    assign address_select_pin_oe_n = spi_pin_oe_n;

endmodule

`default_nettype wire

// file: hdl/srap_pkg.sv
// Purpose: Shared constants and types for the serial register access port
// Assumes: 7-bit register index, 8-bit registers
// Notes: Control bit positions are named here only

package srap_pkg;

    // Register array geometry
    localparam int REG_IDX_W = 7;
    localparam int REG_DEPTH = 128;
    localparam int BYTE_W = 8;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Control registers and their fields
    localparam logic [6:0] IFACE_CTRL_IDX = 7'h12;
    localparam logic [6:0] SEC_CTRL_IDX = 7'h13;
    localparam int AUTO_INC_BIT = 2;
    localparam int THREE_WIRE_BIT = 0;
    localparam int I2C_OFF_BIT = 2;

    // I2C addressing and framing
    localparam logic [5:0] I2C_ADDR_HIGH = 6'h35;
    localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

    // Idle levels of clock, data, strap and chip select pins
    localparam logic [3:0] PIN_IDLE = 4'hF;

    // SPI bit positions within a frame
    localparam logic [3:0] SPI_RW_POS = 4'h0;
    localparam logic [3:0] SPI_ADDR_END = 4'h7;
    localparam logic [3:0] SPI_DATA_START = 4'h8;
    localparam logic [3:0] SPI_BYTE_END = 4'hF;

    // Timing
    localparam int CLOCK_PERIOD_NS = 40;
    localparam int SPIKE_NS = 50;
    localparam int FILT_CYCLES =
        (SPIKE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // Register write request
    typedef struct packed {
        logic [6:0] index;
        logic [7:0] data;
    } srap_wr_s;

    // I2C slave states
    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_ACK,
        I2C_SUB,
        I2C_WRITE,
        I2C_READ,
        I2C_HOST_ACK
    } srap_i2c_e;

    // Register index after one byte
    function automatic logic [6:0] srap_next_index(
        input logic [6:0] idx,
        input logic inc
    );
        return idx + {6'h00, inc};
    endfunction

endpackage

// file: hdl/srap_sync.sv
// Purpose: Two-flop level synchroniser
// Assumes: Inputs are quasi-static levels or slow pins
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none

module srap_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

`default_nettype wire

// file: hdl/srap_spi_link.sv
// Purpose: SPI slave engine running on the serial port clock
// Assumes: Chip select high clears the frame logic at once
// Notes: Write requests leave by a toggle with held data
`timescale 1ns/1ns
`default_nettype none

module srap_spi_link (
    // Link clock and resets
    input wire logic serial_port_clock,
    input wire logic sys_rst,
    input wire logic cs_n,
    // Serial data
    input wire logic data_in,
    output logic out_bit,
    output logic sda_oe_n,
    output logic pin_oe_n,
    // Configuration, synchronised to this clock
    input wire logic auto_inc_l,
    input wire logic three_wire_l,
    // Register access
    input wire logic [7:0] rd_byte,
    output logic [6:0] index,
    output logic wr_toggle,
    output srap_pkg::srap_wr_s wr_req
);

    logic frame_rst;
    logic [3:0] bit_cnt;
    logic is_read;
    logic [6:0] shreg;
    logic [7:0] tx;
    logic [7:0] rx_byte;
    logic at_cmd;
    logic at_addr;
    logic at_data;
    logic at_byte;

    assign frame_rst = sys_rst | cs_n;
    assign rx_byte = {shreg, data_in};
    assign at_cmd = bit_cnt == srap_pkg::SPI_RW_POS;
    assign at_addr = bit_cnt == srap_pkg::SPI_ADDR_END;
    assign at_data = bit_cnt == srap_pkg::SPI_DATA_START;
    assign at_byte = bit_cnt == srap_pkg::SPI_BYTE_END;

    // Sample on rising edges
    always_ff @(posedge serial_port_clock or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt <= srap_pkg::SPI_RW_POS;
            is_read <= 1'b0;
            shreg <= '0;
            index <= '0;
        end else begin
            shreg <= rx_byte[6:0];
            bit_cnt <= at_byte ? srap_pkg::SPI_DATA_START
                               : bit_cnt + 4'h1;
            if (at_cmd) begin
                is_read <= data_in;
            end
            if (at_addr) begin
                index <= rx_byte[6:0];
            end else if (at_byte) begin
                index <= srap_pkg::srap_next_index(index, auto_inc_l);
            end
        end
    end

    // Write data handed to the system clock
    always_ff @(posedge serial_port_clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_toggle <= 1'b0;
            wr_req <= '0;
        end else if (at_byte && !is_read) begin
            wr_req <= '{index: index, data: rx_byte};
            wr_toggle <= ~wr_toggle;
        end
    end

    // Drive on falling edges from bit 8 onward
    always_ff @(negedge serial_port_clock or posedge frame_rst) begin
        if (frame_rst) begin
            out_bit <= 1'b0;
            tx <= '0;
            sda_oe_n <= 1'b1;
            pin_oe_n <= 1'b1;
        end else if (is_read && at_data) begin
            out_bit <= rd_byte[7];
            tx <= {rd_byte[6:0], 1'b0};
            sda_oe_n <= ~three_wire_l;
            pin_oe_n <= three_wire_l;
        end else begin
            out_bit <= tx[7];
            tx <= {tx[6:0], 1'b0};
        end
    end

endmodule

`default_nettype wire

// file: sim/srap_top_chk.sv
// Purpose: Port checker for the serial register access port
// Assumes: One system clock domain observed
// Notes: Bound to srap_top below
`timescale 1ns/1ns
`default_nettype none
module srap_top_chk #(
    parameter int FILT_CYCLES = srap_pkg::FILT_CYCLES
) (
    // System
    input wire logic clock,
    input wire logic sys_rst,
    // Pins
    input wire logic cs_n,
    input wire logic serial_data_o,
    input wire logic serial_data_oe_n,
    input wire logic address_select_pin_oe_n,
    // Configuration and writes
    input wire logic auto_increment,
    input wire logic three_wire_mode,
    input wire logic i2c_disabled,
    input wire logic reg_write_pulse,
    input wire srap_pkg::srap_wr_s reg_write
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    sdo_release_a: assert property (
        cs_n && $past(cs_n) |-> address_select_pin_oe_n)
        else $error("sdo driven while idle");
    pin_exclusive_a: assert property (
        !address_select_pin_oe_n |-> serial_data_oe_n)
        else $error("both data pins driven");
    spi_quiet_a: assert property (
        (!cs_n && !three_wire_mode) [*5] |-> serial_data_oe_n)
        else $error("data pin driven in spi");
    single_pulse_a: assert property (
        reg_write_pulse |=> !reg_write_pulse)
        else $error("write pulse too long");
    iface_cfg_a: assert property (
        reg_write_pulse && reg_write.index == srap_pkg::IFACE_CTRL_IDX
        |-> ##[0:3] (auto_increment ==
        reg_write.data[srap_pkg::AUTO_INC_BIT] && three_wire_mode ==
        reg_write.data[srap_pkg::THREE_WIRE_BIT]))
        else $error("interface config wrong");
    i2c_off_cfg_a: assert property (
        reg_write_pulse && reg_write.index == srap_pkg::SEC_CTRL_IDX
        |-> ##[0:3] i2c_disabled == reg_write.data[srap_pkg::I2C_OFF_BIT])
        else $error("i2c off config wrong");
    cfg_cause_a: assert property (
        $changed({auto_increment, three_wire_mode, i2c_disabled}) |->
        ##[0:1] (reg_write.index == srap_pkg::IFACE_CTRL_IDX ||
        reg_write.index == srap_pkg::SEC_CTRL_IDX))
        else $error("config changed alone");
    i2c_off_quiet_a: assert property (
        (i2c_disabled && cs_n) [*4] |-> serial_data_oe_n)
        else $error("data pin driven, i2c off");
    open_drain_a: assert property (
        cs_n && $past(cs_n) && !serial_data_oe_n |-> !serial_data_o)
        else $error("i2c drives high");
endmodule
bind srap_top srap_top_chk #(.FILT_CYCLES(FILT_CYCLES)) u_chk (
    .clock(clock),
    .sys_rst(sys_rst),
    .cs_n(cs_n),
    .serial_data_o(serial_data_o),
    .serial_data_oe_n(serial_data_oe_n),
    .address_select_pin_oe_n(address_select_pin_oe_n),
    .auto_increment(auto_increment),
    .three_wire_mode(three_wire_mode),
    .i2c_disabled(i2c_disabled),
    .reg_write_pulse(reg_write_pulse),
    .reg_write(reg_write)
);
`default_nettype wire

// file: sim/srap_host.sv
// Purpose: Host model for SPI and I2C access
// Assumes: Data pin has a pull-up
// Notes: Serial clock stands still between frames
`timescale 1ns/1ns
`default_nettype none
module srap_host (
    // Host drive
    output logic cs_n,
    output logic scl,
    output logic drv_en,
    output logic drv_d,
    // Line levels
    input wire logic sda,
    input wire logic sdo
);
    initial begin
        cs_n = 1'b1;
        scl = 1'b1;
        drv_en = 1'b0;
        drv_d = 1'b0;
    end
    // SPI frame of n bits, host drives the first d
    task automatic spi(input logic [31:0] b, input int n, input int d,
        input bit m0, input bit tw, output logic [23:0] rd);
        rd = '0;
        scl = !m0;
        #37 cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            scl = 1'b0;
            drv_en = i < d;
            drv_d = b[31-i];
            #80 scl = 1'b1;
            rd = {rd[22:0], tw ? sda : sdo};
            #80;
        end
        if (m0)
            scl = 1'b0;
        drv_en = 1'b0;
        #80 cs_n = 1'b1;
        #80 scl = 1'b1;
    endtask
    // One I2C bit, high releases the line
    task automatic i2c_bit(input logic b, output logic s);
        scl = 1'b0;
        #650 drv_en = !b;
        #650 scl = 1'b1;
        s = sda;
        #1250;
    endtask
    // Byte MSB first, then acknowledge slot
    task automatic i2c_byte(input logic [7:0] w, input logic ai,
        output logic [7:0] r, output logic ak);
        for (int i = 7; i >= 0; i--)
            i2c_bit(w[i], r[i]);
        i2c_bit(ai, ak);
    endtask
    // Start, repeated start or stop
    task automatic i2c_cond(input bit stop);
        scl = 1'b0;
        drv_d = 1'b0;
        #650 drv_en = stop;
        #650 scl = 1'b1;
        #1250 drv_en = !stop;
        #1250;
    endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Purpose: Self-checking bench for srap_top
// Assumes: Host model drives clock, chip select and data; the bench drives the strap
// Notes: Data and strap pins resolved here
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clock, sys_rst, strap, ab;
    wire logic cs_n, scl, drv_en, drv_d;
    wire logic sda_o, sda_oe_n, asp_o, asp_oe_n, auto_inc, tw, i2c_off, wp;
    logic [7:0] rb;
    logic [23:0] junk;
    wire srap_pkg::srap_wr_s wr;
    srap_pkg::srap_wr_s last_wr;
    int fails = 0;
    int samples_checked = 0;
    int wr_count = 0;
    wire logic sda;
    wire logic sdo;
    assign sda = !sda_oe_n ? sda_o : (drv_en ? drv_d : 1'b1);
    assign sdo = !asp_oe_n ? asp_o : strap;
    initial begin
        clock = 1'b0;
        forever #20 clock = !clock;
    end
    srap_top #(.FILT_CYCLES(2)) DUT (
        .clock(clock),
        .sys_rst(sys_rst),
        .cs_n(cs_n),
        .serial_port_clock(scl),
        .serial_data_i(sda),
        .serial_data_o(sda_o),
        .serial_data_oe_n(sda_oe_n),
        .address_select_pin_i(sdo),
        .address_select_pin_o(asp_o),
        .address_select_pin_oe_n(asp_oe_n),
        .auto_increment(auto_inc),
        .three_wire_mode(tw),
        .i2c_disabled(i2c_off),
        .reg_write_pulse(wp),
        .reg_write(wr)
    );
    srap_host host (
        .cs_n(cs_n),
        .scl(scl),
        .drv_en(drv_en),
        .drv_d(drv_d),
        .sda(sda),
        .sdo(sdo)
    );
    always @(posedge clock)
        if (wp === 1'b1) begin
            wr_count <= wr_count + 1;
            last_wr <= wr;
        end
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic spi_wr(input logic [6:0] idx, input logic [15:0] d,
        input int n, input bit m0);
        int base;
        base = wr_count;
        host.spi({1'b0, idx, d, 8'h00}, 8 + 8 * n, 32, m0, 1'b0, junk);
        for (int k = 0; k < 80 && wr_count < base + n; k++)
            @(posedge clock);
        repeat (4) @(posedge clock);
        check("write count", 16'(base + n), 16'(wr_count));
    endtask
    task automatic spi_rd(input logic [6:0] idx, input int n, input bit m0,
        input bit t, input logic [15:0] exp);
        host.spi({1'b1, idx, 24'h000000}, 8 + 8 * n, 8, m0, t, junk);
        check("read", exp, n == 2 ? junk[15:0] : {8'h00, junk[7:0]});
    endtask
    task automatic i2c_tx(input logic [7:0] b, input logic ack);
        host.i2c_byte(b, 1'b1, rb, ab);
        check("ack level", {15'h0000, ack}, {15'h0000, ab});
    endtask
    initial begin
        sys_rst = 1'b1;
        strap = 1'b1;
        repeat (10) @(posedge clock);
        #2 sys_rst = 1'b0;
        repeat (4) @(posedge clock);
        check("config", 16'h0000, {13'h0000, auto_inc, tw, i2c_off});
        spi_rd(7'h7F, 1, 1'b0, 1'b0, 16'h0000);
        spi_wr(7'h20, 16'h5A00, 1, 1'b0);
        check("write", {1'b0, 7'h20, 8'h5A}, {1'b0, last_wr});
        spi_rd(7'h20, 1, 1'b1, 1'b0, 16'h005A);
        host.spi({1'b0, 7'h21, 24'hEE0000}, 12, 32, 1'b0, 1'b0, junk);
        repeat (40) @(posedge clock);
        check("partial", 16'h0001, 16'(wr_count));
        spi_wr(srap_pkg::IFACE_CTRL_IDX, 16'h0400, 1, 1'b0);
        check("auto inc", 16'h0001, {15'h0000, auto_inc});
        spi_wr(7'h30, 16'hA1B2, 2, 1'b0);
        spi_rd(7'h30, 2, 1'b0, 1'b0, 16'hA1B2);
        spi_wr(srap_pkg::IFACE_CTRL_IDX, 16'h0000, 1, 1'b0);
        spi_wr(7'h40, 16'hC3D4, 2, 1'b1);
        spi_rd(7'h40, 2, 1'b1, 1'b0, 16'hD4D4);
        spi_wr(srap_pkg::IFACE_CTRL_IDX, 16'h0100, 1, 1'b0);
        check("three wire", 16'h0001, {15'h0000, tw});
        spi_rd(7'h30, 1, 1'b0, 1'b1, 16'h00A1);
        spi_wr(srap_pkg::IFACE_CTRL_IDX, 16'h0000, 1, 1'b0);
        host.i2c_cond(1'b0);
        i2c_tx(8'hD6, 1'b0);
        i2c_tx(8'h50, 1'b0);
        i2c_tx(8'h66, 1'b0);
        host.i2c_cond(1'b1);
        check("i2c write", {1'b0, 7'h50, 8'h66}, {1'b0, last_wr});
        host.i2c_cond(1'b0);
        i2c_tx(8'hD6, 1'b0);
        i2c_tx(8'h50, 1'b0);
        host.i2c_cond(1'b0);
        i2c_tx(8'hD7, 1'b0);
        host.i2c_byte(8'hFF, 1'b0, rb, ab);
        check("i2c read", 16'h0066, {8'h00, rb});
        host.i2c_byte(8'hFF, 1'b1, rb, ab);
        check("i2c read", 16'h0066, {8'h00, rb});
        host.i2c_cond(1'b1);
        host.i2c_cond(1'b0);
        i2c_tx(8'hD4, 1'b1);
        host.i2c_cond(1'b1);
        spi_wr(srap_pkg::IFACE_CTRL_IDX, 16'h0400, 1, 1'b0);
        host.i2c_cond(1'b0);
        i2c_tx(8'hD6, 1'b0);
        i2c_tx(8'h60, 1'b0);
        i2c_tx(8'h11, 1'b0);
        i2c_tx(8'h22, 1'b0);
        host.i2c_cond(1'b1);
        spi_rd(7'h60, 2, 1'b0, 1'b0, 16'h1122);
        @(posedge clock);
        #2 strap = 1'b0;
        host.i2c_cond(1'b0);
        i2c_tx(8'hD4, 1'b0);
        host.i2c_cond(1'b1);
        spi_wr(srap_pkg::SEC_CTRL_IDX, 16'h0400, 1, 1'b0);
        check("i2c off", 16'h0001, {15'h0000, i2c_off});
        host.i2c_cond(1'b0);
        i2c_tx(8'hD4, 1'b1);
        host.i2c_cond(1'b1);
        summarize();
    end
    initial begin
        #3000000;
        fails++;
        summarize();
    end
endmodule
`default_nettype wire
